// >>> dart_timer.sv
// Dual 12-bit auto-reload PWM timer with dead time, break, compare and capture
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "dart_map.svh"

module dart_timer
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] breakInputPin,
    input wire logic captureInputPin,
    output logic [3:0] pwmOut,
    output logic irqOut
);
    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [4:0] ctrl_r;
    dart_pkg::dart_cnt_t reloadOne_r, reloadTwo_r, upcounterOne_r, upcounterTwo_r;
    dart_pkg::dart_cnt_t dutyPre_r [4];
    dart_pkg::dart_cnt_t dutyAct_r [4];
    logic [7:0] pwmCtl_r, deadPre_r, deadAct_r;
    logic [3:0] polAct_r, cmpFlag_r, pwmRaw_r;
    logic [11:0] brkCtl_r;
    logic [1:0] brkAct_r, brkS1_r, brkS2_r;
    logic capFlag_r, capS1_r, capS2_r, capS3_r;
    dart_pkg::dart_cnt_t capVal_r;
    logic dtOut0_r, dtOut1_r;
    logic [6:0] dtCnt_r;
    dart_pkg::dart_dtst_e dtSt_r;

    // ------------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction : hit

    wire logic dual = ctrl_r[`DART_CTRL_CNT2EN];
    wire logic wrEn = psel && penable && pwrite;
    wire logic rdEn = psel && penable && !pwrite;
    wire logic mapped = (paddr[1:0] == 2'b00) && (paddr <= `DART_OFF_CNT);
    wire logic capRead = rdEn && hit(paddr, `DART_OFF_CAPT);
    // Break gating per counter and per output
    wire logic anyBrk = |brkAct_r;
    wire logic brkOne = anyBrk && brkCtl_r[`DART_BRK_APPLY1];
    wire logic brkTwo = anyBrk && brkCtl_r[`DART_BRK_APPLY2];
    wire logic [3:0] chanBrk = dual ? {brkTwo, brkTwo, brkOne, brkOne} : {4{brkOne}};
    wire logic ovfOne = (upcounterOne_r == `DART_CNT_TOP);
    wire logic ovfTwo = (upcounterTwo_r == `DART_CNT_TOP);
    wire logic [3:0] chanOvf = dual ? {ovfTwo, ovfTwo, ovfOne, ovfOne} : {4{ovfOne}};
    wire logic [3:0] chanTran = dual ? {{2{ctrl_r[`DART_CTRL_TRANSFER_BIT_TWO]}}, {2{ctrl_r[`DART_CTRL_TRANSFER_BIT_ONE]}}}
        : {4{ctrl_r[`DART_CTRL_TRANSFER_BIT_ONE]}};
    wire dart_pkg::dart_cnt_t nxtOne = ovfOne ? reloadOne_r : upcounterOne_r + 12'h001;
    wire dart_pkg::dart_cnt_t nxtTwo = ovfTwo ? reloadTwo_r : upcounterTwo_r + 12'h001;
    wire dart_pkg::dart_cnt_t cntTwoSel = dual ? nxtTwo : nxtOne;
    wire logic [3:0] chanMatch;
    // Break pin detection
    wire logic [1:0] pinLevel = brkS2_r ~^ brkCtl_r[`DART_BRK_LEVEL_LSB +: 2];
    wire logic [1:0] pinHit;
    wire logic capEdge = capS2_r ^ capS3_r;
    wire logic dtOn = deadAct_r[`DART_DT_ENABLE];
    wire logic [6:0] dtLen = deadAct_r[6:0];

    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_match
            // nonzero duty only, matched as the counter arrives so the pin is low at duty
            assign chanMatch[i] = (dutyAct_r[i] != 12'h000)
                && (dutyAct_r[i] == ((i >= 2) ? cntTwoSel : nxtOne));
        end
        for (genvar b = 0; b < 2; b++)
        begin : g_brk
            // selected, enabled pin at its level
            assign pinHit[b] = brkCtl_r[`DART_BRK_PINEN_LSB + b] && brkCtl_r[`DART_BRK_SEL_LSB + b] && pinLevel[b];
        end
    endgenerate

    wire logic [31:0] rdMux =
        hit(paddr, `DART_OFF_CTRL) ? {27'h0, ctrl_r} :
        hit(paddr, `DART_OFF_RELOAD1) ? {20'h0, reloadOne_r} :
        hit(paddr, `DART_OFF_RELOAD2) ? {20'h0, reloadTwo_r} :
        hit(paddr, `DART_OFF_DUTY0) ? {20'h0, dutyPre_r[0]} :
        hit(paddr, `DART_OFF_DUTY1) ? {20'h0, dutyPre_r[1]} :
        hit(paddr, `DART_OFF_DUTY2) ? {20'h0, dutyPre_r[2]} :
        hit(paddr, `DART_OFF_DUTY3) ? {20'h0, dutyPre_r[3]} :
        hit(paddr, `DART_OFF_PWMCTL) ? {24'h0, pwmCtl_r} :
        hit(paddr, `DART_OFF_DEADT) ? {24'h0, deadPre_r} :
        hit(paddr, `DART_OFF_BREAK) ? {18'h0, brkAct_r, brkCtl_r} :
        hit(paddr, `DART_OFF_STATUS) ? {26'h0, irqOut, capFlag_r, cmpFlag_r} :
        hit(paddr, `DART_OFF_CAPT) ? {20'h0, capVal_r} :
        hit(paddr, `DART_OFF_CNT) ? {4'h0, upcounterTwo_r, 4'h0, upcounterOne_r} : `DART_SLVERR_DATA;

    // ------------------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            prdata <= (psel && !penable && !pwrite) ? rdMux : 32'h0000_0000;
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    // Control, mode and break configuration writes
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_r <= `DART_CTRL_RST;
            pwmCtl_r <= 8'h00;
            deadPre_r <= 8'h00;
            brkCtl_r <= 12'h000;
        end
        else if (wrEn)
        begin
            if (hit(paddr, `DART_OFF_CTRL))
                ctrl_r <= pwdata[4:0];
            if (hit(paddr, `DART_OFF_PWMCTL))
                pwmCtl_r <= pwdata[7:0];
            if (hit(paddr, `DART_OFF_DEADT))
                deadPre_r <= pwdata[7:0];
            if (hit(paddr, `DART_OFF_BREAK))
                brkCtl_r <= pwdata[11:0];
        end
    end

    // ------------------------------------------------------------------------
    // Counters and reload values
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            upcounterOne_r <= 12'h000;
            upcounterTwo_r <= 12'h000;
            reloadOne_r <= 12'h000;
            reloadTwo_r <= 12'h000;
        end
        else
        begin
            if (anyBrk)
            begin
                reloadOne_r <= 12'h000;
                reloadTwo_r <= 12'h000;
            end
            else if (wrEn && hit(paddr, `DART_OFF_RELOAD1))
                reloadOne_r <= pwdata[11:0];
            else if (wrEn && hit(paddr, `DART_OFF_RELOAD2))
                reloadTwo_r <= pwdata[11:0];
            if (brkOne)
                upcounterOne_r <= 12'h000;
            else if (!anyBrk)
                upcounterOne_r <= nxtOne;
            if (brkTwo)
                upcounterTwo_r <= 12'h000;
            else if (!anyBrk && dual)
                upcounterTwo_r <= nxtTwo;
        end
    end

    // ------------------------------------------------------------------------
    // Duty preload, active transfer, polarity and raw PWM
    // ------------------------------------------------------------------------
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_chan
            always_ff @(posedge ref_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    dutyPre_r[i] <= 12'h000;
                    dutyAct_r[i] <= 12'h000;
                    polAct_r[i] <= 1'b0;
                    pwmRaw_r[i] <= 1'b0;
                    cmpFlag_r[i] <= 1'b0;
                end
                else
                begin
                    if (anyBrk)
                        dutyPre_r[i] <= 12'h000;
                    else if (wrEn && hit(paddr, 12'(`DART_OFF_DUTY0 + 4 * i)))
                        dutyPre_r[i] <= pwdata[11:0];
                    if (anyBrk)
                        dutyAct_r[i] <= 12'h000;
                    else if (chanOvf[i] && chanTran[i])
                    begin
                        dutyAct_r[i] <= dutyPre_r[i];
                        polAct_r[i] <= pwmCtl_r[`DART_PWM_POL_LSB + i];
                    end
                    // high at overflow, low at match
                    if (chanOvf[i])
                        pwmRaw_r[i] <= 1'b1;
                    else if (chanMatch[i])
                        pwmRaw_r[i] <= 1'b0;
                    if (chanMatch[i])
                        cmpFlag_r[i] <= 1'b1;
                    else if (wrEn && hit(paddr, `DART_OFF_STATUS) && pwdata[`DART_ST_CMP_LSB + i])
                        cmpFlag_r[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Dead time generator for outputs 0 and 1
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            deadAct_r <= 8'h00;
            dtSt_r <= dart_pkg::DART_DT_IDLE;
            dtCnt_r <= 7'h00;
            dtOut0_r <= 1'b0;
            dtOut1_r <= 1'b0;
        end
        else
        begin
            if (ovfOne)
                deadAct_r <= deadPre_r;
            case (dtSt_r)
                dart_pkg::DART_DT_IDLE, dart_pkg::DART_DT_ON:
                begin
                    if (ovfOne || chanMatch[0])
                    begin
                        dtOut0_r <= 1'b0;
                        dtOut1_r <= 1'b0;
                        dtCnt_r <= 7'h01;
                        dtSt_r <= dart_pkg::DART_DT_WAIT;
                    end
                end
                dart_pkg::DART_DT_WAIT:
                begin
                    if (dtCnt_r >= dtLen)
                    begin
                        dtOut0_r <= pwmRaw_r[0];
                        dtOut1_r <= !pwmRaw_r[0];
                        dtSt_r <= dart_pkg::DART_DT_ON;
                    end
                    else
                        dtCnt_r <= dtCnt_r + 7'h01;
                end
                default:
                    dtSt_r <= dart_pkg::DART_DT_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Output stage: dead time, polarity, enable, break pattern
    // ------------------------------------------------------------------------
    wire logic [3:0] shaped;
    assign shaped[0] = !dtOn ? pwmRaw_r[0] : ((dtLen == 7'h00) ? 1'b0 : dtOut0_r);
    assign shaped[1] = !dtOn ? pwmRaw_r[1] : ((dtLen == 7'h00) ? 1'b0 : dtOut1_r);
    assign shaped[3:2] = pwmRaw_r[3:2];
    wire logic [3:0] inverted = shaped ^ polAct_r;
    wire logic [3:0] oe = pwmCtl_r[`DART_PWM_OE_LSB +: 4];
    // pattern after inverter while break holds
    wire logic [3:0] pinNxt = oe & ((chanBrk & brkCtl_r[`DART_BRK_PAT_LSB +: 4]) | (~chanBrk & inverted));

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pwmOut <= 4'h0;
            irqOut <= 1'b0;
        end
        else
        begin
            pwmOut <= pinNxt;
            irqOut <= (ctrl_r[`DART_CTRL_COMPARE_IRQ_ENABLE] && |cmpFlag_r) || (ctrl_r[`DART_CTRL_CAPTURE_IRQ_ENABLE] && capFlag_r);
        end
    end

    // ------------------------------------------------------------------------
    // Pin synchronisers, break flags and input capture
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            brkS1_r <= 2'b00;
            brkS2_r <= 2'b00;
            capS1_r <= 1'b0;
            capS2_r <= 1'b0;
            capS3_r <= 1'b0;
            brkAct_r <= 2'b00;
            capFlag_r <= 1'b0;
            capVal_r <= 12'h000;
        end
        else
        begin
            brkS1_r <= breakInputPin;
            brkS2_r <= brkS1_r;
            capS1_r <= captureInputPin;
            capS2_r <= capS1_r;
            capS3_r <= capS2_r;
            // software set and clear, pin set wins
            brkAct_r <= (wrEn && hit(paddr, `DART_OFF_BREAK)) ? (pwdata[`DART_BRK_ACT_LSB +: 2] | pinHit)
                : (brkAct_r | pinHit);
            if (capEdge && !capFlag_r)
            begin
                capVal_r <= upcounterOne_r;
                capFlag_r <= 1'b1;
            end
            else if (capRead)
                capFlag_r <= 1'b0;
        end
    end
endmodule : dart_timer

// >>> dart_map.svh
// Register offsets, field positions, reset values and timing counts of the dual reload PWM timer
`ifndef DART_MAP_SVH
`define DART_MAP_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define DART_OFF_CTRL 12'h000
`define DART_OFF_RELOAD1 12'h004
`define DART_OFF_RELOAD2 12'h008
`define DART_OFF_DUTY0 12'h00c
`define DART_OFF_DUTY1 12'h010
`define DART_OFF_DUTY2 12'h014
`define DART_OFF_DUTY3 12'h018
`define DART_OFF_PWMCTL 12'h01c
`define DART_OFF_DEADT 12'h020
`define DART_OFF_BREAK 12'h024
`define DART_OFF_STATUS 12'h028
`define DART_OFF_CAPT 12'h02c
`define DART_OFF_CNT 12'h030

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DART_CTRL_CNT2EN 0
`define DART_CTRL_TRANSFER_BIT_ONE 1
`define DART_CTRL_TRANSFER_BIT_TWO 2
`define DART_CTRL_COMPARE_IRQ_ENABLE 3
`define DART_CTRL_CAPTURE_IRQ_ENABLE 4
`define DART_PWM_OE_LSB 0
`define DART_PWM_POL_LSB 4
`define DART_DT_ENABLE 7
`define DART_BRK_PAT_LSB 0
`define DART_BRK_PINEN_LSB 4
`define DART_BRK_LEVEL_LSB 6
`define DART_BRK_SEL_LSB 8
`define DART_BRK_APPLY1 10
`define DART_BRK_APPLY2 11
`define DART_BRK_ACT_LSB 12
`define DART_ST_CMP_LSB 0
`define DART_ST_CAPF 4
`define DART_ST_IRQ 5

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define DART_CTRL_RST 5'h06
`define DART_CNT_TOP 12'hfff
`define DART_SLVERR_DATA 32'h0000_0000

`endif

// >>> dart_pkg.sv
// Types shared by the dual reload PWM timer
package dart_pkg;
    typedef logic [11:0] dart_cnt_t;
    typedef enum logic [1:0]
    {
        DART_DT_IDLE = 2'b00,
        DART_DT_WAIT = 2'b01,
        DART_DT_ON = 2'b10
    } dart_dtst_e;
endpackage : dart_pkg

// >>> dart_timer_props.sv
// Port-level assertions for the dual reload PWM timer
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Checker
// ----------------------------------------------------------------------------
module dart_timer_props
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] breakInputPin,
    input wire logic captureInputPin,
    input wire logic [3:0] pwmOut,
    input wire logic irqOut
);
    // Setup phase and address decode
    wire logic setupSeen = psel && !penable;
    wire logic badAddr = (paddr > 12'h030) || (paddr[1:0] != 2'h0);

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    ack_after_setup_a: assert property (setupSeen |=> pready) else $error("pready missing after setup");
    ack_single_a: assert property (pready |=> !pready) else $error("pready held too long");
    ack_idle_a: assert property (!psel |=> !pready) else $error("pready without request");
    unmapped_err_a: assert property (setupSeen && badAddr |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (setupSeen && !badAddr |=> !pslverr) else $error("mapped access refused");
    ctrl_upper_a: assert property (setupSeen && !pwrite && paddr == 12'h000 |=> prdata[31:5] == 27'h0)
        else $error("control read upper bits set");
    capt_width_a: assert property (setupSeen && paddr == 12'h02c |=> prdata[31:12] == 20'h0)
        else $error("capture read wider than counter");
    reset_quiet_a: assert property ($rose(rst_n) |-> pwmOut == 4'h0 && !irqOut)
        else $error("outputs active at reset release");
endmodule : dart_timer_props

bind dart_timer dart_timer_props i_props (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .breakInputPin(breakInputPin), .captureInputPin(captureInputPin), .pwmOut(pwmOut), .irqOut(irqOut));

// >>> dart_stage.sv
// Power stage and external break and capture source model
`timescale 1ns/1ps
module dart_stage
(
    input wire logic ref_clk,
    input wire logic [3:0] pwmOut,
    input wire logic [1:0] breakReq,
    input wire logic captureReq,
    output logic [1:0] breakInputPin,
    output logic captureInputPin,
    output int overlapCount
);
    initial
    begin
        breakInputPin = 2'h0;
        captureInputPin = 1'b0;
        overlapCount = 0;
    end

    // pins driven after edge, overlap counted
    always @(posedge ref_clk)
    begin
        breakInputPin <= breakReq;
        captureInputPin <= captureReq;
        if (pwmOut[0] === 1'b1 && pwmOut[1] === 1'b1)
            overlapCount <= overlapCount + 1;
    end
endmodule : dart_stage

// >>> dual_autoreload_pwm_timer_tb.sv
// Self-checking testbench of the dual reload PWM timer
`timescale 1ns/1ps
`include "dart_map.svh"
module dual_autoreload_pwm_timer_tb;
    logic ref_clk, rst_n, psel, penable, pwrite, captureReq, pready, pslverr, irqOut, err, captureInputPin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] breakInputPin, breakReq;
    logic [3:0] pwmOut;
    int mismatches, samples_checked, cyc, seed, rl, dt, per, hi, t, c0, ov, overlapCount;

    dart_timer i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .breakInputPin(breakInputPin), .captureInputPin(captureInputPin), .pwmOut(pwmOut), .irqOut(irqOut));
    dart_stage i_stage (.ref_clk(ref_clk), .pwmOut(pwmOut), .breakReq(breakReq), .captureReq(captureReq),
        .breakInputPin(breakInputPin), .captureInputPin(captureInputPin), .overlapCount(overlapCount));

    // ------------------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Hang guard
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            mismatches++;
            summarize();
        end
    end

    task summarize();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 50)
            mismatches++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic waitLvl(input int b, input logic l);
        int n;
        n = 0;
        while (pwmOut[b] !== l && n < 9000)
        begin
            @(posedge ref_clk);
            n++;
        end
    endtask : waitLvl

    // Period and high time of one output, after a full overflow
    task meas(input int b);
        waitLvl(b, 1'b1);
        waitLvl(b, 1'b0);
        waitLvl(b, 1'b1);
        t = cyc;
        waitLvl(b, 1'b0);
        hi = cyc - t;
        waitLvl(b, 1'b1);
        per = cyc - t;
    endtask : meas

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        seed = 96320;
        {rst_n, psel, penable, pwrite, captureReq, paddr, pwdata, breakReq} = '0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1'b0, `DART_OFF_CTRL, 32'h0);
        chk("ctrl", 32'h6, rd);
        apb(1'b0, `DART_OFF_DUTY0, 32'h0);
        chk("duty0", 32'h0, rd);
        apb(1'b1, 12'h040, 32'hffff_ffff);
        chk("slverr", 32'h1, err);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped", 32'h0, rd);
        // Random single mode waveforms, odd outputs inverted
        for (int i = 0; i < 4; i++)
        begin
            rl = 4000 + ($unsigned($random(seed)) % 80);
            dt = rl + 1 + ($unsigned($random(seed)) % 10);
            apb(1'b1, `DART_OFF_RELOAD1, rl);
            apb(1'b1, 12'(`DART_OFF_DUTY0 + 4 * i), dt);
            apb(1'b1, `DART_OFF_PWMCTL, 32'h0f | ((i % 2) << (4 + i)));
            meas(i);
            chk("period", 4096 - rl, per);
            chk("high", (i % 2) ? 4096 - dt : dt - rl, hi);
        end
        // Dual mode on counter two
        apb(1'b1, `DART_OFF_RELOAD2, 32'd4060);
        apb(1'b1, `DART_OFF_DUTY2, 32'd4070);
        apb(1'b1, `DART_OFF_CTRL, 32'h7);
        meas(2);
        chk("period2", 32'd36, per);
        chk("high2", 32'd10, hi);
        // Compare flag and its interrupt
        apb(1'b1, `DART_OFF_CTRL, 32'hf);
        // Clear stale compare flags so only counter two can set flag 2 again
        apb(1'b1, `DART_OFF_STATUS, 32'hf);
        repeat (100) @(posedge ref_clk);
        apb(1'b0, `DART_OFF_STATUS, 32'h0);
        chk("cmpflag2", 32'h1, rd[2]);
        chk("cmpirq", 32'h1, irqOut);
        // Capture: second edge ignored while flag set
        apb(1'b1, `DART_OFF_CTRL, 32'h16);
        apb(1'b1, `DART_OFF_RELOAD1, 32'h0);
        repeat (120) @(posedge ref_clk);
        apb(1'b0, `DART_OFF_CNT, 32'h0);
        c0 = rd[11:0];
        captureReq <= ~captureReq;
        repeat (30) @(posedge ref_clk);
        captureReq <= ~captureReq;
        repeat (30) @(posedge ref_clk);
        chk("capirq", 32'h1, irqOut);
        apb(1'b0, `DART_OFF_CAPT, 32'h0);
        t = (rd[11:0] - c0) & 32'hfff;
        chk("capwindow", 32'h1, (t >= 2 && t <= 16));
        apb(1'b0, `DART_OFF_STATUS, 32'h0);
        chk("capclear", 32'h0, rd[4]);
        // Dead time between outputs zero and one
        apb(1'b1, `DART_OFF_CTRL, 32'h6);
        apb(1'b1, `DART_OFF_RELOAD1, 32'd4000);
        apb(1'b1, `DART_OFF_DUTY0, 32'd4050);
        apb(1'b1, `DART_OFF_PWMCTL, 32'h3);
        apb(1'b1, `DART_OFF_DEADT, 32'h83);
        waitLvl(0, 1'b0);
        waitLvl(0, 1'b1);
        ov = overlapCount;
        waitLvl(0, 1'b0);
        t = cyc;
        waitLvl(1, 1'b1);
        chk("deadgap", 32'd3, cyc - t);
        repeat (200) @(posedge ref_clk);
        chk("overlap", ov, overlapCount);
        apb(1'b1, `DART_OFF_DEADT, 32'h80);
        repeat (250) @(posedge ref_clk);
        chk("dtzero", 32'h0, pwmOut[1:0]);
        apb(1'b1, `DART_OFF_DEADT, 32'h0);
        // Software break
        apb(1'b1, `DART_OFF_PWMCTL, 32'hf);
        apb(1'b1, `DART_OFF_BREAK, 32'h140a);
        repeat (4) @(posedge ref_clk);
        chk("brkpat", 32'ha, pwmOut);
        apb(1'b0, `DART_OFF_RELOAD1, 32'h0);
        chk("brkreload", 32'h0, rd);
        apb(1'b0, `DART_OFF_DUTY0, 32'h0);
        chk("brkduty", 32'h0, rd);
        apb(1'b0, `DART_OFF_CNT, 32'h0);
        chk("brkcnt", 32'h0, rd[11:0]);
        apb(1'b1, `DART_OFF_BREAK, 32'h0);
        apb(1'b1, `DART_OFF_RELOAD1, 32'd4090);
        apb(1'b1, `DART_OFF_DUTY0, 32'd4093);
        meas(0);
        chk("resume", 32'd6, per);
        // Break from pin zero, active high
        apb(1'b1, `DART_OFF_BREAK, 32'h551);
        breakReq <= 2'b01;
        repeat (8) @(posedge ref_clk);
        apb(1'b0, `DART_OFF_BREAK, 32'h0);
        chk("pinflag", 32'h1, rd[12]);
        chk("pinpat", 32'h1, pwmOut);
        breakReq <= 2'b00;
        repeat (4) @(posedge ref_clk);
        apb(1'b1, `DART_OFF_BREAK, 32'h0);
        apb(1'b0, `DART_OFF_BREAK, 32'h0);
        chk("pinclear", 32'h0, rd[12]);
        summarize();
    end
endmodule : dual_autoreload_pwm_timer_tb
